// File: logic/irq_ctrl.sv
// Interrupt controller: pins, software, groups and selectable peripheral sources to CPU.
// Assumes all request inputs except pins are synchronous to clock_i and register strobes are
// single-cycle pulses from a master on the same clock.
`timescale 1ns/100ps
`include "irq_ctrl_consts.svh"
module irq_ctrl #(
  parameter int          NSLOW     = 128,
  parameter int          NFAST     = 64,
  parameter logic [127:0] SLOW_EDGE = 128'h0,
  parameter logic [63:0]  FAST_EDGE = 64'h0,
  parameter int          FILT_DIV  = 4
) (
  input  wire logic                     clock_i,
  input  wire logic                     rstn_i,
  input  wire logic [11:0]              addr_i,
  input  wire logic [31:0]              wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [31:0]              rdata_o,
  input  wire logic [15:0]              ext_pin_request_i,
  input  wire logic                     nmi_pin_i,
  input  wire irq_ctrl_pkg::nmi_src_t   nmi_src_i,
  input  wire irq_ctrl_pkg::wake_src_t  wake_src_i,
  input  wire logic [127:0]             grp_lines_i,
  input  wire logic [NSLOW-1:0]         slow_src_i,
  input  wire logic [NFAST-1:0]         fast_src_i,
  input  wire irq_ctrl_pkg::power_mode_t pmode_i,
  input  wire logic                     cpu_ack_i,
  input  wire logic [7:0]               cpu_ack_vec_i,
  input  wire logic                     xfer_ack_i,
  output irq_ctrl_pkg::irq_req_t        cpu_req_o,
  output logic                          fast_irq_o,
  output irq_ctrl_pkg::irq_req_t        xfer_req_o,
  output logic                          dma_start_o,
  output logic                          nmi_o,
  output logic                          wake_o
);
  // --------------------------------------------------------------------------
  // Reset release and decode helpers
  // --------------------------------------------------------------------------
  logic       rst_meta_q;
  logic       rstn_q;
  // Release is synchronised so that no flop leaves reset on a different edge.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rstn_q     <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rstn_q     <= rst_meta_q;
    end
  end
  // Block match on the upper address bits; sh is the block size exponent.
  function automatic logic in_blk(input logic [11:0] a, input logic [11:0] b, input int sh);
    in_blk = ((a >> sh) == (b >> sh));
  endfunction : in_blk
  logic wr_prio;
  logic wr_vctl;
  logic wr_sel;
  assign wr_prio = wr_i && in_blk(addr_i, `A_PRIO_BASE, 8);
  assign wr_vctl = wr_i && in_blk(addr_i, `A_VCTL_BASE, 8);
  assign wr_sel  = wr_i && in_blk(addr_i, `A_SEL_BASE, 7);
  // --------------------------------------------------------------------------
  // Pin synchronisers and noise filters
  // --------------------------------------------------------------------------
  logic [16:0] pin_meta_q;
  logic [16:0] pin_sync_q;
  logic [16:0] pin_filt_q;
  logic [16:0] pin_h1_q;
  logic [16:0] pin_h2_q;
  logic [16:0] pin_prev_q;
  logic [16:0] pin_lvl;
  logic [16:0] filt_en_q;
  logic [7:0]  fdiv_q;
  logic        ftick;
  // Two flops before anything looks at the pins; NMI rides as bit 16.
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      pin_meta_q <= 17'h1FFFF;
      pin_sync_q <= 17'h1FFFF;
    end else begin
      pin_meta_q <= {nmi_pin_i, ext_pin_request_i};
      pin_sync_q <= pin_meta_q;
    end
  end
  // Sample tick for the filter; a slower tick rejects longer glitches.
  assign ftick = (fdiv_q == 8'(FILT_DIV - 1));
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      fdiv_q <= 8'h00;
    end else begin
      fdiv_q <= ftick ? 8'h00 : fdiv_q + 8'h01;
    end
  end
  // The filtered level moves only after three equal samples.
  genvar gp;
  generate
    for (gp = 0; gp < 17; gp++) begin : g_filt
      always_ff @(posedge clock_i or negedge rstn_q) begin
        if (!rstn_q) begin
          pin_h1_q[gp]   <= 1'b1;
          pin_h2_q[gp]   <= 1'b1;
          pin_filt_q[gp] <= 1'b1;
        end else if (ftick) begin
          pin_h1_q[gp] <= pin_sync_q[gp];
          pin_h2_q[gp] <= pin_h1_q[gp];
          if (pin_sync_q[gp] == pin_h1_q[gp] && pin_h1_q[gp] == pin_h2_q[gp]) begin
            pin_filt_q[gp] <= pin_h2_q[gp];
          end
        end
      end
      assign pin_lvl[gp] = filt_en_q[gp] ? pin_filt_q[gp] : pin_sync_q[gp];
    end
  endgenerate
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      pin_prev_q <= 17'h1FFFF;
    end else begin
      pin_prev_q <= pin_lvl;
    end
  end
  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic [3:0]  prio_q [0:255];
  logic [7:0]  sel_q  [0:127];
  logic [255:0] xfer_en_q;
  logic [31:0] detect_q;
  logic        nmi_rise_q;
  logic [8:0]  fast_q;
  logic        guard_q;
  logic [8:0]  dma_q;
  logic [15:0] deep_mask_q;
  logic [31:0] grp_en_q [0:3];
  logic        soft1_q;
  logic        soft2_q;
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      for (int i = 0; i < 256; i++) begin
        prio_q[i] <= `PRIO_RST;
      end
    end else if (wr_prio) begin
      prio_q[addr_i[7:0]] <= wdata_i[3:0];
    end
  end
  // Vectors below the first transfer-capable one keep their bit at zero.
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      xfer_en_q <= '0;
    end else if (wr_vctl && addr_i[7:0] >= `V_XFER_FIRST) begin
      xfer_en_q[addr_i[7:0]] <= wdata_i[0];
    end
  end
  // Remapping a live vector is dangerous, hence the guard.
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      for (int i = 0; i < 128; i++) begin
        sel_q[i] <= `SEL_NONE;
      end
    end else if (wr_sel && guard_q) begin
      sel_q[addr_i[6:0]] <= wdata_i[7:0];
    end
  end
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      detect_q    <= '0;
      filt_en_q   <= '0;
      nmi_rise_q  <= 1'b0;
      fast_q      <= '0;
      guard_q     <= 1'b0;
      dma_q       <= '0;
      deep_mask_q <= '0;
      for (int g = 0; g < 4; g++) begin
        grp_en_q[g] <= '0;
      end
    end else if (wr_i) begin
      if (addr_i == `A_DETECT) begin
        detect_q <= wdata_i;
      end else if (addr_i == `A_FILT_EN) begin
        filt_en_q <= wdata_i[16:0];
      end else if (addr_i == `A_NMI_EDGE) begin
        nmi_rise_q <= wdata_i[0];
      end else if (addr_i == `A_FAST_CTL) begin
        fast_q <= wdata_i[8:0];
      end else if (addr_i == `A_SEL_GUARD) begin
        guard_q <= wdata_i[0];
      end else if (addr_i == `A_DMA_CTL) begin
        dma_q <= wdata_i[8:0];
      end else if (addr_i == `A_DEEP_MASK) begin
        deep_mask_q <= wdata_i[15:0];
      end else if (in_blk(addr_i, `A_GRP_EN, 2)) begin
        grp_en_q[addr_i[1:0]] <= wdata_i;
      end
    end
  end
  // Trigger writes give a single-cycle event.
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      soft1_q <= 1'b0;
      soft2_q <= 1'b0;
    end else begin
      soft1_q <= wr_i && addr_i == `A_SOFT_ONE && wdata_i[0];
      soft2_q <= wr_i && addr_i == `A_SOFT_TWO && wdata_i[0];
    end
  end
  // --------------------------------------------------------------------------
  // Source collection
  // --------------------------------------------------------------------------
  logic [255:0] evt;
  logic [255:0] lvl;
  logic [255:0] is_edge;
  logic [NSLOW-1:0] slow_prev_q;
  logic [NFAST-1:0] fast_prev_q;
  logic [31:0] grp_req [0:3];
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      slow_prev_q <= '0;
      fast_prev_q <= '0;
    end else begin
      slow_prev_q <= slow_src_i;
      fast_prev_q <= fast_src_i;
    end
  end
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      grp_req[g] = grp_lines_i[g*32 +: 32];
    end
  end
  always_comb begin
    int s;
    s       = 0;
    evt     = '0;
    lvl     = '0;
    is_edge = '0;
    evt[`V_SOFT_ONE]     = soft1_q;
    evt[`V_SOFT_TWO]     = soft2_q;
    is_edge[`V_SOFT_ONE] = 1'b1;
    is_edge[`V_SOFT_TWO] = 1'b1;
    for (int i = 0; i < 16; i++) begin
      case (detect_q[2*i +: 2])
        `DET_LOW: lvl[`V_EXT_BASE + i] = ~pin_lvl[i];
        `DET_FALL: evt[`V_EXT_BASE + i] = pin_prev_q[i] & ~pin_lvl[i];
        `DET_RISE: evt[`V_EXT_BASE + i] = ~pin_prev_q[i] & pin_lvl[i];
        default: evt[`V_EXT_BASE + i] = pin_prev_q[i] ^ pin_lvl[i];
      endcase
      is_edge[`V_EXT_BASE + i] = (detect_q[2*i +: 2] != `DET_LOW);
    end
    // Groups are level sources; each lands on one vector.
    for (int g = 0; g < 4; g++) begin
      lvl[`V_GRP_BASE + g] = |(grp_req[g] & grp_en_q[g]);
    end
    // The edge or level nature follows the source, never the vector.
    for (int v = 0; v < 128; v++) begin
      s = int'(sel_q[v]);
      if (v < 80 && s < NSLOW) begin
        is_edge[`V_SLOW_BASE + v] = SLOW_EDGE[s];
        evt[`V_SLOW_BASE + v] = slow_src_i[s] & ~slow_prev_q[s];
        lvl[`V_SLOW_BASE + v] = slow_src_i[s];
      end else if (v >= 80 && s < NFAST) begin
        is_edge[`V_SLOW_BASE + v] = FAST_EDGE[s];
        evt[`V_SLOW_BASE + v] = fast_src_i[s] & ~fast_prev_q[s];
        lvl[`V_SLOW_BASE + v] = fast_src_i[s];
      end
    end
  end
  // --------------------------------------------------------------------------
  // Pending flags and arbitration
  // --------------------------------------------------------------------------
  logic [255:0] pend_q;
  logic [255:0] pend_d;
  logic [255:0] clr;
  irq_ctrl_pkg::irq_req_t cpu_d;
  irq_ctrl_pkg::irq_req_t xfr_d;
  always_comb begin
    clr = '0;
    if (cpu_ack_i) begin
      clr[cpu_ack_vec_i] = 1'b1;
    end
    if (xfer_ack_i && xfer_req_o.valid) begin
      clr[xfer_req_o.vector] = 1'b1;
    end
    if (dma_q[`DMA_EN_BIT]) begin
      clr[dma_q[7:0]] = 1'b1;
    end
    for (int v = 0; v < 256; v++) begin
      // A new edge in the clearing cycle is kept.
      pend_d[v] = is_edge[v] ? (evt[v] | (pend_q[v] & ~clr[v])) : lvl[v];
    end
  end
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end
  // Scan upward with a strict compare so the lower vector keeps a tie.
  always_comb begin
    cpu_d = '0;
    xfr_d = '0;
    for (int v = 0; v < 256; v++) begin
      if (pend_q[v] && prio_q[v] != 4'h0
          && !(fast_q[`FAST_EN_BIT] && fast_q[7:0] == 8'(v))
          && !(dma_q[`DMA_EN_BIT] && dma_q[7:0] == 8'(v))) begin
        if (xfer_en_q[v]) begin
          if (!xfr_d.valid || prio_q[v] > xfr_d.level) begin
            xfr_d = '{1'b1, 8'(v), prio_q[v]};
          end
        end else if (!cpu_d.valid || prio_q[v] > cpu_d.level) begin
          cpu_d = '{1'b1, 8'(v), prio_q[v]};
        end
      end
    end
  end
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      cpu_req_o   <= '0;
      xfer_req_o  <= '0;
      fast_irq_o  <= 1'b0;
      dma_start_o <= 1'b0;
    end else begin
      cpu_req_o   <= cpu_d;
      xfer_req_o  <= xfr_d;
      fast_irq_o  <= fast_q[`FAST_EN_BIT] && pend_q[fast_q[7:0]];
      dma_start_o <= dma_q[`DMA_EN_BIT] && pend_d[dma_q[7:0]];
    end
  end
  // --------------------------------------------------------------------------
  // Non-maskable sources
  // --------------------------------------------------------------------------
  logic [6:0] nm_stat_q;
  logic [6:0] nm_en_q;
  logic [6:0] nm_set;
  logic       nmi_pin_evt;
  assign nmi_pin_evt = nmi_rise_q ? (~pin_prev_q[16] & pin_lvl[16])
                                  : (pin_prev_q[16] & ~pin_lvl[16]);
  assign nm_set = {nmi_src_i.ram_parity, nmi_src_i.lvd_two, nmi_src_i.lvd_one,
                   nmi_src_i.independent_watchdog_fault, nmi_src_i.wdt_fault,
                   nmi_src_i.osc_stop, nmi_pin_evt};
  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      nm_stat_q <= '0;
    end else begin
      nm_stat_q <= nm_set | (nm_stat_q & ~((wr_i && addr_i == `A_NM_STATUS) ? wdata_i[6:0]
                                                                           : 7'h00));
    end
  end
  // Enables can only be turned on, so a runaway program cannot drop them.
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      nm_en_q <= '0;
      nmi_o   <= 1'b0;
    end else begin
      if (wr_i && addr_i == `A_NM_ENABLE) begin
        nm_en_q <= nm_en_q | wdata_i[6:0];
      end
      nmi_o <= |(nm_stat_q & nm_en_q);
    end
  end
  // --------------------------------------------------------------------------
  // Wake-up from low-power states
  // --------------------------------------------------------------------------
  logic ext_act;
  logic deep_ext;
  logic common_wake;
  assign ext_act  = |(evt[`V_EXT_BASE +: 16] | lvl[`V_EXT_BASE +: 16]);
  assign deep_ext = |((evt[`V_EXT_BASE +: 16] | lvl[`V_EXT_BASE +: 16]) & deep_mask_q);
  assign common_wake = nmi_pin_evt | nmi_src_i.lvd_one | nmi_src_i.lvd_two
                     | wake_src_i.rtc_alarm | wake_src_i.rtc_period;
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      wake_o <= 1'b0;
    end else begin
      case (pmode_i)
        irq_ctrl_pkg::PM_SLEEP: wake_o <= (|pend_q) | (|nm_stat_q);
        irq_ctrl_pkg::PM_ALLSTOP: wake_o <= common_wake | ext_act | nmi_src_i.osc_stop
            | nmi_src_i.independent_watchdog_fault | wake_src_i.remote_control_receiver_event
            | (|pend_q[`V_WAKE_LAST:`V_WAKE_FIRST]);
        irq_ctrl_pkg::PM_STANDBY: wake_o <= common_wake | ext_act
            | nmi_src_i.independent_watchdog_fault | wake_src_i.remote_control_receiver_event;
        irq_ctrl_pkg::PM_DEEP: wake_o <= common_wake | deep_ext;
        default: wake_o <= 1'b0;
      endcase
    end
  end
  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    if (in_blk(addr_i, `A_PRIO_BASE, 8)) begin
      rd_d[3:0] = prio_q[addr_i[7:0]];
    end else if (in_blk(addr_i, `A_VCTL_BASE, 8)) begin
      rd_d[0] = xfer_en_q[addr_i[7:0]];
      rd_d[`VCTL_PEND_BIT] = pend_q[addr_i[7:0]];
    end else if (in_blk(addr_i, `A_SEL_BASE, 7)) begin
      rd_d[7:0] = sel_q[addr_i[6:0]];
    end else if (addr_i == `A_DETECT) begin
      rd_d = detect_q;
    end else if (addr_i == `A_FILT_EN) begin
      rd_d[16:0] = filt_en_q;
    end else if (addr_i == `A_NMI_EDGE) begin
      rd_d[0] = nmi_rise_q;
    end else if (addr_i == `A_NM_STATUS) begin
      rd_d[6:0] = nm_stat_q;
    end else if (addr_i == `A_NM_ENABLE) begin
      rd_d[6:0] = nm_en_q;
    end else if (addr_i == `A_FAST_CTL) begin
      rd_d[8:0] = fast_q;
    end else if (addr_i == `A_SEL_GUARD) begin
      rd_d[0] = guard_q;
    end else if (addr_i == `A_DMA_CTL) begin
      rd_d[8:0] = dma_q;
    end else if (addr_i == `A_DEEP_MASK) begin
      rd_d[15:0] = deep_mask_q;
    end else if (addr_i == `A_CPU_STAT) begin
      rd_d[12:0] = {cpu_req_o.valid, cpu_req_o.vector, cpu_req_o.level};
    end else if (in_blk(addr_i, `A_GRP_REQ, 2)) begin
      rd_d = grp_req[addr_i[1:0]];
    end else if (in_blk(addr_i, `A_GRP_EN, 2)) begin
      rd_d = grp_en_q[addr_i[1:0]];
    end
  end
  // Data stand for exactly the cycle after the read strobe.
  always_ff @(posedge clock_i or negedge rstn_q) begin
    if (!rstn_q) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_d : 32'h0000_0000;
    end
  end
endmodule : irq_ctrl

// File: logic/irq_ctrl_consts.svh
// Address map, vector numbers, field positions and reset values of the interrupt controller.
// Assumes inclusion by bare name from files under logic/.
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------------
`define A_PRIO_BASE    12'h000
`define A_VCTL_BASE    12'h100
`define A_SEL_BASE     12'h200
`define A_DETECT       12'h280
`define A_FILT_EN      12'h281
`define A_NMI_EDGE     12'h282
`define A_NM_STATUS    12'h283
`define A_NM_ENABLE    12'h284
`define A_SOFT_ONE     12'h285
`define A_SOFT_TWO     12'h286
`define A_FAST_CTL     12'h287
`define A_SEL_GUARD    12'h288
`define A_DMA_CTL      12'h289
`define A_DEEP_MASK    12'h28A
`define A_CPU_STAT     12'h28B
`define A_GRP_REQ      12'h290
`define A_GRP_EN       12'h294
// ----------------------------------------------------------------------------
// Vector numbers
// ----------------------------------------------------------------------------
`define V_SOFT_TWO     8'h1A
`define V_SOFT_ONE     8'h1B
`define V_XFER_FIRST   8'h1A
`define V_EXT_BASE     8'h40
`define V_GRP_BASE     8'h6E
`define V_SLOW_BASE    8'h80
`define V_FAST_BASE    8'hD0
`define V_WAKE_FIRST   8'h92
`define V_WAKE_LAST    8'h9D
// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define DET_LOW        2'h0
`define DET_FALL       2'h1
`define DET_RISE       2'h2
`define DET_BOTH       2'h3
`define NM_PIN         0
`define NM_OSC         1
`define NM_WDT         2
`define NM_INDEPENDENT_WATCHDOG        3
`define NM_VOLTAGE_MONITOR_ONE        4
`define NM_VOLTAGE_MONITOR_TWO        5
`define NM_RAM         6
`define FAST_EN_BIT    8
`define DMA_EN_BIT     8
`define VCTL_PEND_BIT  1
`define PRIO_RST       4'h0
`define SEL_NONE       8'hFF
`endif

// File: logic/irq_ctrl_pkg.sv
// Types shared by the interrupt controller and its surroundings.
// Assumes the constants header is included where numbers are needed.
package irq_ctrl_pkg;
  // Low-power state reported by the power controller, one-hot.
  typedef enum logic [4:0] {
    PM_RUN     = 5'b00001,
    PM_SLEEP   = 5'b00010,
    PM_ALLSTOP = 5'b00100,
    PM_STANDBY = 5'b01000,
    PM_DEEP    = 5'b10000
  } power_mode_t;
  // Non-maskable event pulses from on-chip monitors.
  typedef struct packed {
    logic osc_stop;
    logic wdt_fault;
    logic independent_watchdog_fault;
    logic lvd_one;
    logic lvd_two;
    logic ram_parity;
  } nmi_src_t;
  // Extra wake-up event pulses.
  typedef struct packed {
    logic rtc_alarm;
    logic rtc_period;
    logic remote_control_receiver_event;
  } wake_src_t;
  // Request presented to the CPU or to the transfer controller.
  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
    logic [3:0] level;
  } irq_req_t;
endpackage : irq_ctrl_pkg

// File: bench/irq_ctrl_assertions.sv
// Concurrent checks on the controller's register port, non-maskable path and CPU request.
// Assumes one clock and the bench's idle cycle between a write and the following read.
`timescale 1ns/100ps
module irq_ctrl_assertions (
  input wire logic                      clock_i,
  input wire logic                      rstn_i,
  input wire logic [11:0]               addr_i,
  input wire logic [31:0]               wdata_i,
  input wire logic                      wr_i,
  input wire logic                      rd_i,
  input wire logic [31:0]               rdata_o,
  input wire irq_ctrl_pkg::nmi_src_t    nmi_src_i,
  input wire irq_ctrl_pkg::power_mode_t pmode_i,
  input wire irq_ctrl_pkg::irq_req_t    cpu_req_o,
  input wire logic                      nmi_o,
  input wire logic                      wake_o
);
  logic [6:0] en_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Shadow of the set-only enable word, so a clear that sneaks through is caught.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) en_q <= 7'h00;
    else if (wr_i && addr_i == 12'h284) en_q <= en_q | wdata_i[6:0];
  end
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  prio_readback_a: assert property (wr_i && addr_i < 12'h100 ##2 rd_i && $stable(addr_i)
    |=> rdata_o[3:0] == $past(wdata_i[3:0], 3)) else $error("priority read back wrong");
  xfer_low_a: assert property (wr_i && addr_i inside {[12'h100:12'h119]} ##2 rd_i
    && $stable(addr_i) |=> !rdata_o[0]) else $error("transfer enable below 26 took a write");
  nm_enable_a: assert property (rd_i && addr_i == 12'h284 |=> rdata_o[6:0] == en_q)
    else $error("non-maskable enable word wrong");
  nmi_ram_a: assert property (nmi_src_i.ram_parity && en_q[6] |-> ##2 nmi_o)
    else $error("enabled RAM error gave no nmi");
  nmi_gate_a: assert property (nmi_o |-> en_q != 7'h00)
    else $error("nmi with nothing enabled");
  level_zero_a: assert property (cpu_req_o.valid |-> cpu_req_o.level != 4'h0)
    else $error("level zero presented");
  sleep_wake_a: assert property ($past(pmode_i) == irq_ctrl_pkg::PM_SLEEP && nmi_o
    |-> wake_o) else $error("pending nmi did not end sleep");
endmodule : irq_ctrl_assertions
bind irq_ctrl irq_ctrl_assertions irq_ctrl_assertions_inst (.clock_i(clock_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .nmi_src_i(nmi_src_i), .pmode_i(pmode_i), .cpu_req_o(cpu_req_o), .nmi_o(nmi_o),
  .wake_o(wake_o));

// File: bench/cpu_partner.sv
// Behavioural CPU core that accepts whatever request the controller presents.
// Assumes the controller drops an accepted request two cycles after the accept.
`timescale 1ns/100ps
module cpu_partner (
  input  wire logic                   clock_i,
  input  wire irq_ctrl_pkg::irq_req_t req_i,
  input  wire logic [3:0]             delay_i,
  output logic                        ack_o,
  output logic [7:0]                  vec_o
);
  int wait_q = 0;
  initial ack_o = 1'b0;
  initial vec_o = 8'h00;
  // A long delay lets a later, stronger request overtake the one first shown.
  always @(posedge clock_i) begin
    ack_o <= 1'b0;
    vec_o <= ~vec_o; // Meaningless without the accept, so it never looks stable.
    if (wait_q < 0 || !req_i.valid) wait_q <= (wait_q < 0) ? wait_q + 1 : 0;
    else if (wait_q == int'(delay_i)) begin
      ack_o  <= 1'b1;
      vec_o  <= req_i.vector;
      wait_q <= -3;
    end else wait_q <= wait_q + 1;
  end
endmodule : cpu_partner

// File: bench/irq_ctrl_bench.sv
// Self-checking bench: register port, non-maskable path, wake-up and CPU arbitration.
// Assumes the checker is bound into the controller and the CPU model answers its requests.
`timescale 1ns/100ps
module irq_ctrl_bench;
  logic                      clock_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic                      rd_q = 1'b0, ack, wake_o;
  logic [11:0]               addr_i = 12'h000;
  logic [31:0]               wdata_i = 32'h0, rdata_o, r, seed = 32'd93;
  logic [16:0]               pins = 17'h1FFFF;
  logic                      fast, dma;
  int                        dmas = 0;
  logic [8:0]                ev = 9'h000;
  logic [7:0]                vec;
  logic [3:0]                delay = 4'd3;
  irq_ctrl_pkg::power_mode_t pmode = irq_ctrl_pkg::PM_RUN;
  irq_ctrl_pkg::irq_req_t    req;
  logic [31:0]               exp_q[$];
  logic [7:0]                vec_q[$];
  int                        miscompares = 0, total_checks = 0;
  always #12.5 clock_i = ~clock_i;
  irq_ctrl irq_ctrl_inst (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_pin_request_i(pins[15:0]), .nmi_pin_i(pins[16]), .nmi_src_i(ev[8:3]),
    .wake_src_i(ev[2:0]), .grp_lines_i(128'h0), .slow_src_i(128'h0), .fast_src_i(64'h0),
    .pmode_i(pmode), .cpu_ack_i(ack), .cpu_ack_vec_i(vec), .xfer_ack_i(1'b0),
    .cpu_req_o(req), .fast_irq_o(fast), .xfer_req_o(), .dma_start_o(dma), .nmi_o(),
    .wake_o(wake_o));
  cpu_partner cpu_partner_inst (.clock_i(clock_i), .req_i(req), .delay_i(delay),
    .ack_o(ack), .vec_o(vec));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
  endtask : rd
  task automatic pulse(input logic [8:0] v);
    @(posedge clock_i);
    ev <= v;
    @(posedge clock_i);
    ev <= 9'h000;
  endtask : pulse
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // Results are taken mid-cycle, where registered outputs have settled.
  always @(negedge clock_i) begin
    if (rd_q) cmp(rdata_o, exp_q.pop_front());
    if (ack) cmp({24'h0, vec}, {24'h0, vec_q.pop_front()});
    if (dma) dmas++; // A start pulse stands one cycle, so each is counted once.
    rd_q = rd_i;
  end
  initial begin
    #50us;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      wr(12'h030 + i[11:0], {28'h0, r[3:0]});
      rd(12'h030 + i[11:0], {28'h0, r[3:0]});
    end
    rd(12'h2FF, 32'h0);
    wr(12'h119, 32'h1);
    rd(12'h119, 32'h0);
    wr(12'h11A, 32'h1);
    rd(12'h11A, 32'h1);
    wr(12'h11A, 32'h0);
    wr(12'h200, 32'h5);
    rd(12'h200, 32'hFF);
    wr(12'h288, 32'h1);
    wr(12'h200, 32'h5);
    rd(12'h200, 32'h5);
    wr(12'h284, 32'h42);
    wr(12'h284, 32'h0);
    rd(12'h284, 32'h42);
    pulse(9'h008);
    rd(12'h283, 32'h40);
    wr(12'h283, 32'h40);
    rd(12'h283, 32'h0);
    pmode <= irq_ctrl_pkg::PM_SLEEP;
    pulse(9'h100);
    repeat (3) @(posedge clock_i);
    pmode <= irq_ctrl_pkg::PM_STANDBY;
    wr(12'h283, 32'h02);
    pulse(9'h100);
    repeat (2) @(negedge clock_i) cmp({31'h0, wake_o}, 32'h0);
    pulse(9'h004);
    @(negedge clock_i) cmp({31'h0, wake_o}, 32'h1);
    pmode <= irq_ctrl_pkg::PM_RUN;
    wr(12'h01A, 32'h3);
    wr(12'h01B, 32'h3);
    vec_q = '{8'h1A, 8'h1B};
    wr(12'h285, 32'h1);
    wr(12'h286, 32'h1);
    repeat (20) @(posedge clock_i);
    wr(12'h280, 32'h1);
    wr(12'h040, 32'h7);
    delay <= 4'd6;
    vec_q = '{8'h40, 8'h1A};
    wr(12'h286, 32'h1);
    pins[0] <= 1'b0;
    repeat (30) @(posedge clock_i);
    pins[0] <= 1'b1;
    repeat (10) @(posedge clock_i);
    wr(12'h287, 32'h11B);
    wr(12'h289, 32'h11A);
    wr(12'h285, 32'h1);
    wr(12'h286, 32'h1);
    pins[16] <= 1'b0;
    repeat (6) @(posedge clock_i);
    cmp({31'h0, fast}, 32'h1);
    cmp(dmas, 32'h1);
    rd(12'h283, 32'h3);
    repeat (4) @(posedge clock_i);
    cmp(vec_q.size(), 32'h0);
    complete_run();
  end
endmodule : irq_ctrl_bench
